/* logic/pot_pkg.sv */
package pot_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [11:0] TRIM_REG_ADDR = 12'hf9b;
  localparam logic [11:0] STATUS_REG_ADDR = 12'hf9c;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  localparam int LOW_SRC_BIT = 7;
  localparam int MULT_EN_BIT = 6;
  localparam int TRIM_MSB = 5;
  localparam int TRIM_W = 6;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_ON_MULT_BIT = 1;
  localparam int STAT_SLOW_RUN_BIT = 2;
  localparam int STAT_MULT_RUN_BIT = 3;

  // ****************************************************
  // Clock figures
  // ****************************************************
  localparam int CORE_PERIOD_NS = 40;
  localparam int CORE_KHZ = 25000;
  localparam int MULT_OUT_MHZ = 96;
  localparam int MULT_REF_MHZ = 4;
  localparam int CORE_MAX_MHZ = 48;
  localparam int USB_FS_MHZ = 48;
  localparam int USB_LS_MHZ = 6;
  localparam int FAST_OSC_KHZ = 8000;
  localparam int SLOW_RC_KHZ = 31;
  localparam int LOW_FREQ_DIV = 256;
  localparam int LOCK_TIME_NS = 2000000;
  localparam int TRIM_SLEW_NS = 320;
  localparam int TRIM_SLEW_CYCLES =
    (TRIM_SLEW_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

  // Phase accumulator model of the free running oscillators
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] FAST_INC =
    ACC_W'((FAST_OSC_KHZ * 65536) / CORE_KHZ);
  localparam logic [ACC_W-1:0] SLOW_INC =
    ACC_W'((SLOW_RC_KHZ * 65536) / CORE_KHZ);
  localparam logic [ACC_W-1:0] TRIM_STEP = 16'h0040;

  // Divide ratios taken from the multiplied clock; the last one divides the bypass USB clock
  localparam logic [7:0] MULT_CORE_DIV = 8'(MULT_OUT_MHZ / CORE_MAX_MHZ);
  localparam logic [7:0] USB_FS_DIV = 8'(MULT_OUT_MHZ / USB_FS_MHZ);
  localparam logic [7:0] USB_LS_DIV = 8'(MULT_OUT_MHZ / USB_LS_MHZ);
  localparam logic [7:0] USB_LS_BYP_DIV = 8'(USB_FS_MHZ / USB_LS_MHZ);

  // Oscillator configuration modes
  typedef enum logic [2:0] {
    MODE_EC,
    MODE_EC_MULT,
    MODE_XTAL,
    MODE_XTAL_MULT,
    MODE_INT,
    MODE_INT_CLKO,
    MODE_INT_MULT,
    MODE_INT_MULT_CLKO
  } pot_osc_mode_t;

endpackage

/* logic/pot_tick_div.sv */
`timescale 1ns/10ps
// Divides a stream of single-cycle ticks by a run-time ratio
module pot_tick_div
  import pot_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Tick stream
  input wire logic inTick,
  input wire logic clear,
  input wire logic [W-1:0] divide,
  output logic outTick
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_d;
  logic tick_d;

  // Count input ticks; clear restarts a full period
  always_comb begin
    count_d = count_q;
    tick_d = 1'b0;
    if (clear) begin
      count_d = '0;
    end else if (inTick) begin
      if (count_q >= divide - W'(1)) begin
        count_d = '0;
        tick_d = 1'b1;
      end else begin
        count_d = count_q + W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      outTick <= 1'b0;
    end else begin
      count_q <= count_d;
      outTick <= tick_d;
    end
  end

endmodule // pot_tick_div

/* logic/pot_trim_slew.sv */
`timescale 1ns/10ps
// Walks the applied trim one step at a time toward the written value
module pot_trim_slew
  import pot_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Trim values, two's complement
  input wire logic [TRIM_W-1:0] target,
  output logic [TRIM_W-1:0] applied
);

  localparam int CW = $clog2(TRIM_SLEW_CYCLES + 1);

  logic [CW-1:0] wait_q;
  logic [CW-1:0] wait_d;
  logic [TRIM_W-1:0] applied_d;

  // One step per slew interval; no completion flag on purpose
  always_comb begin
    applied_d = applied;
    wait_d = wait_q;
    if (applied == target) begin
      wait_d = '0;
    end else if (wait_q < CW'(TRIM_SLEW_CYCLES - 1)) begin
      wait_d = wait_q + CW'(1);
    end else begin
      wait_d = '0;
      if ($signed(target) > $signed(applied)) begin
        applied_d = applied + TRIM_W'(1);
      end else begin
        applied_d = applied - TRIM_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= '0;
      applied <= TRIM_RESET[TRIM_MSB:0];
    end else begin
      wait_q <= wait_d;
      applied <= applied_d;
    end
  end

endmodule // pot_trim_slew

/* logic/pot_clock_ctrl.sv */
`timescale 1ns/10ps
// Behaviour
// - Multiplier only in multiplied modes when enabled, or while the core still runs on it
// - Multiplier turns 4 MHz into 96 MHz
// - Eight-way prescaler brings input to 4 MHz
// - Core divider by 1, 2, 3 or 6
// - Fast oscillator 8 MHz, postscaler to 31 kHz
// - Fast oscillator with multiplier gives 48 MHz
// - Slow RC runs when selected or needed
// - Frequency select picks fast, slow or postscaled
// - Trim change slews gradually, no done flag
// - Bit 7 picks fast/256 or slow RC
// - Non-multiplied modes keep multiplier off once the core has left it
// - Bypass clock until lock, then auto switch
// - Bit 6 enables the multiplier
// - Trim is two's complement, constant step
// - Trim never affects the slow RC
// - USB gets 48 MHz or 6 MHz
// - Core stays on bypass while locking
module pot_clock_ctrl
  import pot_pkg::*;
#(
  parameter int LOCK_NS = LOCK_TIME_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  // Configuration
  input wire logic [2:0] oscMode,
  input wire logic [2:0] prescaleSel,
  input wire logic [1:0] cpuDivSel,
  input wire logic [2:0] internal_freq_select,
  input wire logic useInternalClk,
  input wire logic usbFullSpeed,
  // Features that need the slow RC
  input wire logic powerUpTimerEn,
  input wire logic failSafeEn,
  input wire logic watchdogEn,
  input wire logic twoSpeedEn,
  // Primary oscillator pin
  input wire logic primaryClkPin,
  // Generated clock ticks and status
  output logic coreTick,
  output logic usbTick,
  output logic internalTick,
  output logic multRunning,
  output logic multLocked,
  output logic coreOnMult,
  output logic slowRcRunning,
  output logic [5:0] appliedTrim
);

  localparam int LOCK_CYCLES = (LOCK_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int LW = $clog2(LOCK_CYCLES + 1);

  // ****************************************************
  // Decode helpers
  // ****************************************************
  function automatic logic [7:0] prescaleDiv(input logic [2:0] sel);
    case (sel)
      3'h0: prescaleDiv = 8'h0c;
      3'h1: prescaleDiv = 8'h0a;
      3'h2: prescaleDiv = 8'h06;
      3'h3: prescaleDiv = 8'h05;
      3'h4: prescaleDiv = 8'h04;
      3'h5: prescaleDiv = 8'h03;
      3'h6: prescaleDiv = 8'h02;
      default: prescaleDiv = 8'h01;
    endcase
  endfunction

  function automatic logic [7:0] cpuDiv(input logic [1:0] sel);
    case (sel)
      2'h0: cpuDiv = 8'h06;
      2'h1: cpuDiv = 8'h03;
      2'h2: cpuDiv = 8'h02;
      default: cpuDiv = 8'h01;
    endcase
  endfunction

  function automatic logic isMultMode(input pot_osc_mode_t m);
    case (m)
      MODE_EC_MULT, MODE_XTAL_MULT, MODE_INT_MULT,
      MODE_INT_MULT_CLKO: isMultMode = 1'b1;
      default: isMultMode = 1'b0;
    endcase
  endfunction

  function automatic logic isIntMode(input pot_osc_mode_t m);
    isIntMode = (m == MODE_INT) || (m == MODE_INT_CLKO) ||
      (m == MODE_INT_MULT) || (m == MODE_INT_MULT_CLKO);
  endfunction

  pot_osc_mode_t mode;
  assign mode = pot_osc_mode_t'(oscMode);

  // ****************************************************
  // Trim register and status
  // ****************************************************
  logic [7:0] trimReg_q;
  logic [7:0] trimReg_d;
  logic [7:0] rdata_d;
  logic lowSrcFast;
  logic multEnable;

  assign lowSrcFast = trimReg_q[LOW_SRC_BIT];
  assign multEnable = trimReg_q[MULT_EN_BIT];

  // Unmapped addresses read zero and ignore writes
  always_comb begin
    trimReg_d = trimReg_q;
    if (regWrite && regAddr == TRIM_REG_ADDR) begin
      trimReg_d = regWdata;
    end
    rdata_d = 8'h00;
    if (regRead) begin
      case (regAddr)
        TRIM_REG_ADDR: rdata_d = trimReg_q;
        STATUS_REG_ADDR: begin
          rdata_d[STAT_LOCKED_BIT] = multLocked;
          rdata_d[STAT_ON_MULT_BIT] = coreOnMult;
          rdata_d[STAT_SLOW_RUN_BIT] = slowRcRunning;
          rdata_d[STAT_MULT_RUN_BIT] = multRunning;
        end
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trimReg_q <= TRIM_RESET;
      regRdata <= 8'h00;
    end else begin
      trimReg_q <= trimReg_d;
      regRdata <= rdata_d;
    end
  end

  // Applied trim follows the written trim gradually
  logic [5:0] trimNow;
  pot_trim_slew u_slew (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .target(trimReg_q[TRIM_MSB:0]),
    .applied(trimNow)
  );

  // ****************************************************
  // Oscillator models
  // ****************************************************
  logic [ACC_W:0] fastAcc_q;
  logic [ACC_W:0] fastAcc_d;
  logic [ACC_W:0] slowAcc_q;
  logic [ACC_W:0] slowAcc_d;
  logic [ACC_W-1:0] fastInc;
  logic slowRun;

  // Signed trim scales a constant step around the centre rate
  assign fastInc = FAST_INC +
    ACC_W'($signed(trimNow) * $signed({1'b0, TRIM_STEP}));

  // Slow RC needed by selection or by a safety feature
  assign slowRun = powerUpTimerEn || failSafeEn || watchdogEn ||
    twoSpeedEn || (useInternalClk && internal_freq_select == 3'h0 &&
    !lowSrcFast);

  // Carry out of each accumulator is one oscillator period
  always_comb begin
    fastAcc_d = {1'b0, fastAcc_q[ACC_W-1:0]} + {1'b0, fastInc};
    slowAcc_d = slowAcc_q;
    if (slowRun) begin
      slowAcc_d = {1'b0, slowAcc_q[ACC_W-1:0]} + {1'b0, SLOW_INC};
    end else begin
      slowAcc_d[ACC_W] = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fastAcc_q <= '0;
      slowAcc_q <= '0;
    end else begin
      fastAcc_q <= fastAcc_d;
      slowAcc_q <= slowAcc_d;
    end
  end

  logic fastTick;
  logic slowTick;
  assign fastTick = fastAcc_q[ACC_W];
  assign slowTick = slowAcc_q[ACC_W];

  // ****************************************************
  // Primary pin synchroniser
  // ****************************************************
  logic pinMeta_q;
  logic pinSync_q;
  logic pinLast_q;

  // Only the second stage is examined for edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinLast_q <= 1'b0;
    end else begin
      pinMeta_q <= primaryClkPin;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  logic pinTick;
  assign pinTick = pinSync_q && !pinLast_q;

  // ****************************************************
  // Internal postscaler and low frequency source
  // ****************************************************
  logic div256Tick;
  logic postTick;
  logic lowFreqTick;
  logic [7:0] postDiv;

  assign postDiv = 8'h01 << (3'h7 - internal_freq_select);

  // Nine bits so the full divide by 256 fits in one stage
  pot_tick_div #(.W(9)) u_div256 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(fastTick),
    .clear(1'b0),
    .divide(9'(LOW_FREQ_DIV)),
    .outTick(div256Tick)
  );

  pot_tick_div u_post (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(fastTick),
    .clear(1'b0),
    .divide(postDiv),
    .outTick(postTick)
  );

  // Low rate clock source choice
  assign lowFreqTick = lowSrcFast ? div256Tick : slowTick;

  logic intSelTick;
  assign intSelTick = (internal_freq_select == 3'h0) ? lowFreqTick :
    postTick;

  // ****************************************************
  // Multiplier control and lock
  // ****************************************************
  logic multWanted;
  logic [LW-1:0] lockCnt_q;
  logic [LW-1:0] lockCnt_d;
  logic locked_d;
  logic onMult_d;
  logic multRun;

  // Internal clock selection, at any frequency select, also stops the multiplier
  assign multWanted = multEnable && isMultMode(mode) &&
    !useInternalClk;
  assign multRun = multWanted || coreOnMult;

  // Count the lock time from each enable
  always_comb begin
    lockCnt_d = '0;
    locked_d = 1'b0;
    if (multWanted) begin
      if (lockCnt_q < LW'(LOCK_CYCLES)) begin
        lockCnt_d = lockCnt_q + LW'(1);
      end else begin
        lockCnt_d = lockCnt_q;
        // Never report lock before the reference reaches the multiplier
        locked_d = multRunning;
      end
    end
  end

  // ****************************************************
  // Source paths and dividers
  // ****************************************************
  logic primTick;
  logic refTick;
  logic bypassSrcTick;
  logic bypassCoreTick;
  logic multCoreTick;
  logic [7:0] bypassDiv;

  // Internal multiplied modes feed the 8 MHz oscillator to the prescaler
  assign primTick = isIntMode(mode) ? fastTick : pinTick;
  assign bypassSrcTick = (useInternalClk || mode == MODE_INT ||
    mode == MODE_INT_CLKO) ? intSelTick : primTick;
  assign bypassDiv = (bypassSrcTick == intSelTick && useInternalClk) ?
    8'h01 : cpuDiv(cpuDivSel);

  // Reference to the multiplier, nominally the 4 MHz rate
  pot_tick_div u_prescale (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(primTick),
    .clear(!multRun),
    .divide(prescaleDiv(prescaleSel)),
    .outTick(refTick)
  );

  // Each idle path is held cleared so it starts with a full period
  pot_tick_div u_bypass (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(bypassSrcTick),
    .clear(coreOnMult),
    .divide(bypassDiv),
    .outTick(bypassCoreTick)
  );

  // Every core cycle stands for one multiplied clock period
  pot_tick_div u_multcore (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(multRun),
    .clear(!coreOnMult),
    .divide(8'(MULT_CORE_DIV * cpuDiv(cpuDivSel))),
    .outTick(multCoreTick)
  );

  pot_tick_div u_usb (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inTick(multRun ? 1'b1 : primTick),
    .clear(1'b0),
    .divide(multRun ? (usbFullSpeed ? USB_FS_DIV : USB_LS_DIV) :
      (usbFullSpeed ? 8'h01 : USB_LS_BYP_DIV)),
    .outTick(usbTick)
  );

  // Switch only at the end of a period of the current source
  always_comb begin
    onMult_d = coreOnMult;
    if (!coreOnMult && multLocked && bypassCoreTick) begin
      onMult_d = 1'b1;
    end else if (coreOnMult && !multLocked && multCoreTick) begin
      onMult_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockCnt_q <= '0;
      multLocked <= 1'b0;
      coreOnMult <= 1'b0;
      multRunning <= 1'b0;
      coreTick <= 1'b0;
      internalTick <= 1'b0;
      slowRcRunning <= 1'b0;
      appliedTrim <= 6'h00;
    end else begin
      lockCnt_q <= lockCnt_d;
      multLocked <= locked_d;
      coreOnMult <= onMult_d;
      multRunning <= multRun && refTick | multRunning && multRun;
      coreTick <= coreOnMult ? multCoreTick : bypassCoreTick;
      internalTick <= intSelTick;
      slowRcRunning <= slowRun;
      appliedTrim <= trimNow;
    end
  end

endmodule // pot_clock_ctrl

/* test/pot_clock_ctrl_chk.sv */
`timescale 1ns/10ps
module pot_clock_ctrl_chk
  import pot_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port and configuration
  input wire logic regRead,
  input wire logic [7:0] regRdata,
  input wire logic [2:0] oscMode,
  input wire logic [1:0] cpuDivSel,
  input wire logic usbFullSpeed,
  input wire logic powerUpTimerEn,
  input wire logic failSafeEn,
  input wire logic watchdogEn,
  input wire logic twoSpeedEn,
  // Generated ticks and status
  input wire logic coreTick,
  input wire logic usbTick,
  input wire logic multRunning,
  input wire logic multLocked,
  input wire logic coreOnMult,
  input wire logic slowRcRunning,
  input wire logic [5:0] appliedTrim
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Read data only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(regRead) |-> regRdata == 8'h00)
    else $error("read data outside its cycle");
  AST_MULT_MODE: assert property ($rose(multRunning) |->
    oscMode inside {3'h1, 3'h3, 3'h6, 3'h7})
    else $error("multiplier started in a plain mode");
  AST_LOCK_WAIT: assert property ($rose(multLocked) |->
    $past(multRunning) && !coreOnMult) else $error("lock before reference");
  AST_SWITCH_AFTER_LOCK: assert property ($rose(coreOnMult) |->
    multLocked) else $error("core switched before lock");
  // Multiplier must outlive the core's use of it, else a runt period
  AST_MULT_HELD: assert property (coreOnMult |-> multRunning)
    else $error("multiplier stopped under the core");
  AST_CORE_DIV1: assert property (coreOnMult && $past(coreOnMult) &&
    cpuDivSel == 2'h3 && coreTick |=> !coreTick ##1
    (coreTick || !coreOnMult || cpuDivSel != 2'h3))
    else $error("core tick spacing wrong");
  AST_USB_FS: assert property (usbTick && usbFullSpeed &&
    coreOnMult && $past(usbFullSpeed) && $past(multRunning) |=> !usbTick ##1
    (usbTick || !usbFullSpeed || !multRunning))
    else $error("usb tick spacing wrong");
  AST_SLOW_FORCED: assert property (powerUpTimerEn || failSafeEn ||
    watchdogEn || twoSpeedEn |-> ##[0:3] slowRcRunning)
    else $error("slow oscillator not forced on");
  AST_TRIM_STEP: assert property ($changed(appliedTrim) |->
    6'(appliedTrim - $past(appliedTrim)) inside {6'h01, 6'h3f})
    else $error("trim jumped more than one step");
  AST_TRIM_SLEW: assert property ($changed(appliedTrim) |=>
    $stable(appliedTrim) [*7]) else $error("trim moved too fast");

  // Main scenarios reached
  cover property ($rose(coreOnMult));
  cover property ($changed(appliedTrim));
  cover property (usbTick && !usbFullSpeed && multRunning);
endmodule // pot_clock_ctrl_chk

bind pot_clock_ctrl pot_clock_ctrl_chk chk_u (.core_clk(core_clk),
  .rst_n(rst_n), .regRead(regRead), .regRdata(regRdata),
  .oscMode(oscMode), .cpuDivSel(cpuDivSel), .usbFullSpeed(usbFullSpeed),
  .powerUpTimerEn(powerUpTimerEn), .failSafeEn(failSafeEn),
  .watchdogEn(watchdogEn), .twoSpeedEn(twoSpeedEn), .coreTick(coreTick),
  .usbTick(usbTick), .multRunning(multRunning), .multLocked(multLocked),
  .coreOnMult(coreOnMult), .slowRcRunning(slowRcRunning),
  .appliedTrim(appliedTrim));

/* test/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import pot_pkg::*;
  // ****************************************************
  // Signals
  // ****************************************************
  typedef struct {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] e;}
    pot_tb_row_t;
  // Short lock so the run stays brief: 10 cycles
  localparam int LOCK_SIM_NS = 400;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  logic [2:0] oscMode = 3'h6;
  logic [2:0] prescaleSel = 3'h6;
  logic [1:0] cpuDivSel = 2'h3;
  logic [2:0] freqSel = 3'h0;
  logic useInternalClk = 1'b0;
  logic usbFullSpeed = 1'b1;
  logic [3:0] safetyEn = 4'h0;
  logic primaryClkPin = 1'b0;
  logic coreTick, usbTick, internalTick, multRunning;
  logic multLocked, coreOnMult, slowRcRunning;
  logic [5:0] appliedTrim;
  int failures = 0;
  int check_count = 0;
  pot_tb_row_t rows [6] = '{'{12'hf9b, 1'b0, 8'h00, 8'h00},
    '{12'hf9b, 1'b1, 8'h3f, 8'h3f}, '{12'hf9b, 1'b1, 8'h80, 8'h80},
    '{12'h123, 1'b1, 8'ha5, 8'h00}, '{12'hf9c, 1'b1, 8'hff, 8'h00},
    '{12'hf9b, 1'b1, 8'h00, 8'h00}};
  logic [1:0] divCode [5] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3};
  int divVal [5] = '{1, 2, 3, 6, 1};

  // Clocks: core and an unrelated primary oscillator pin
  always #20 core_clk = ~core_clk;
  always #61 primaryClkPin = ~primaryClkPin;

  pot_clock_ctrl #(.LOCK_NS(LOCK_SIM_NS)) dut_u (.core_clk(core_clk),
    .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .oscMode(oscMode), .prescaleSel(prescaleSel), .cpuDivSel(cpuDivSel),
    .internal_freq_select(freqSel), .useInternalClk(useInternalClk),
    .usbFullSpeed(usbFullSpeed), .powerUpTimerEn(safetyEn[0]),
    .failSafeEn(safetyEn[1]), .watchdogEn(safetyEn[2]),
    .twoSpeedEn(safetyEn[3]), .primaryClkPin(primaryClkPin),
    .coreTick(coreTick), .usbTick(usbTick), .internalTick(internalTick),
    .multRunning(multRunning), .multLocked(multLocked),
    .coreOnMult(coreOnMult), .slowRcRunning(slowRcRunning),
    .appliedTrim(appliedTrim));

  // ****************************************************
  // Tasks
  // ****************************************************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
      input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
        exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // Read data is only valid in the one cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  function automatic logic tk(input int s);
    case (s)
      0: return coreTick;
      1: return usbTick;
      2: return internalTick;
      3: return multLocked;
      4: return coreOnMult;
      default: return multRunning;
    endcase
  endfunction

  // Bounded wait for a level, sampled after each edge settles
  task automatic waitSig(input int s, input logic v, output int c);
    c = 0;
    while (tk(s) !== v && c < 200) begin
      @(posedge core_clk);
      #1 c++;
    end
  endtask

  // Cycles between two successive ticks of one stream
  task automatic gapOf(input int s, output int g);
    int k;
    int t0;
    t0 = -1;
    g = -1;
    for (k = 0; k < 4000 && g < 0; k++) begin
      @(posedge core_clk);
      #1;
      if (tk(s) === 1'b1) begin
        if (t0 >= 0) g = k - t0;
        t0 = k;
      end
    end
  endtask

  task automatic waitTrim(input logic [5:0] t, output int c);
    c = 0;
    while (appliedTrim !== t && c < 1000) begin
      @(posedge core_clk);
      #1 c++;
    end
    cmp(16'(appliedTrim), 16'(t), "trim settled");
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************************
  // Sequence
  // ****************************************************
  initial begin
    #(40 * 60000);
    failures++;
    summarize();
  end

  initial begin
    logic [7:0] r;
    int n;
    int n0;
    int m;
    int e;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    // Register rows: reset value, fields, unmapped, read-only status
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      cmp(16'(r), 16'(rows[i].e), "register row");
    end
    waitTrim(6'h00, n);
    // Enable bit in every mode; only multiplied modes may lock
    for (m = 0; m < 8; m++) begin
      @(posedge core_clk);
      oscMode <= 3'(m);
      prescaleSel <= 3'(m);
      wr(TRIM_REG_ADDR, 8'h40);
      // Slowest reference takes some 30 cycles to reach the multiplier
      repeat (60) @(posedge core_clk);
      #1 cmp(16'(multLocked), 16'(m inside {1, 3, 6, 7}), "mode");
      wr(TRIM_REG_ADDR, 8'h00);
      repeat (30) @(posedge core_clk);
    end
    @(posedge core_clk);
    oscMode <= 3'h6;
    prescaleSel <= 3'h6;
    wr(TRIM_REG_ADDR, 8'h40);
    waitSig(3, 1'b1, n);
    cmp(16'(n >= 10 && n <= 13), 16'h1, "lock time");
    cmp(16'(coreOnMult), 16'h0, "bypass while locking");
    waitSig(4, 1'b1, n);
    rd(STATUS_REG_ADDR, r);
    cmp(16'(r), 16'h000b, "status on multiplier");
    foreach (divCode[i]) begin
      @(posedge core_clk);
      cpuDivSel <= divCode[i];
      gapOf(0, n);
      gapOf(0, n);
      e = divVal[i] * MULT_OUT_MHZ / CORE_MAX_MHZ;
      cmp(16'(n), 16'(e), "core divide");
    end
    for (m = 0; m < 2; m++) begin
      @(posedge core_clk);
      usbFullSpeed <= m[0];
      gapOf(1, n);
      gapOf(1, n);
      e = MULT_OUT_MHZ / (m == 1 ? USB_FS_MHZ : USB_LS_MHZ);
      cmp(16'(n), 16'(e), "usb clock");
    end
    wr(TRIM_REG_ADDR, 8'h00);
    waitSig(5, 1'b0, n);
    cmp(16'(multRunning | coreOnMult), 16'h0, "multiplier off");
    // Each safety feature alone forces the slow oscillator
    for (m = 0; m < 4; m++) begin
      @(posedge core_clk);
      safetyEn <= 4'(1 << m);
      repeat (4) @(posedge core_clk);
      #1 cmp(16'(slowRcRunning), 16'h1, "slow forced");
      @(posedge core_clk) safetyEn <= 4'h0;
      repeat (4) @(posedge core_clk);
      #1 cmp(16'(slowRcRunning), 16'h0, "slow released");
    end
    @(posedge core_clk);
    useInternalClk <= 1'b1;
    gapOf(2, n0);
    cmp(16'(slowRcRunning), 16'h1, "slow selected");
    cmp(16'(n0 > 780 && n0 < 840), 16'h1, "slow rate");
    wr(TRIM_REG_ADDR, 8'h80);
    gapOf(2, n);
    cmp(16'(slowRcRunning), 16'h0, "slow not selected");
    e = CORE_KHZ * LOW_FREQ_DIV / FAST_OSC_KHZ;
    cmp(16'(n >= e && n <= e + 1), 16'h1, "fast over 256");
    // Postscaler settings from divide by 64 up to fast direct
    for (m = 1; m < 8; m++) begin
      @(posedge core_clk);
      freqSel <= 3'(m);
      gapOf(2, n);
      gapOf(2, n);
      e = (CORE_KHZ << (7 - m)) / FAST_OSC_KHZ;
      cmp(16'(n >= e && n <= e + 1), 16'h1, "postscaler");
    end
    @(posedge core_clk);
    freqSel <= 3'h0;
    wr(TRIM_REG_ADDR, 8'h9f);
    waitTrim(6'h1f, n);
    cmp(16'(n >= 31 * 7), 16'h1, "gradual trim");
    gapOf(2, n);
    cmp(16'(n < CORE_KHZ * LOW_FREQ_DIV / FAST_OSC_KHZ), 16'h1, "max");
    wr(TRIM_REG_ADDR, 8'h1f);
    gapOf(2, n);
    cmp(16'(n >= n0 - 1 && n <= n0 + 1), 16'h1, "slow untrimmed");
    wr(TRIM_REG_ADDR, 8'ha0);
    waitTrim(6'h20, n);
    cmp(16'(n >= 63 * 7), 16'h1, "gradual trim down");
    gapOf(2, n);
    cmp(16'(n > CORE_KHZ * LOW_FREQ_DIV / FAST_OSC_KHZ + 1), 16'h1,
      "min");
    // Reset in mid-run clears outputs and the register
    @(posedge core_clk);
    rst_n <= 1'b0;
    @(posedge core_clk);
    #1 cmp(16'({coreTick, slowRcRunning, appliedTrim}), 16'h0, "in reset");
    @(posedge core_clk) rst_n <= 1'b1;
    rd(TRIM_REG_ADDR, r);
    cmp(16'(r), 16'(TRIM_RESET), "reset value");
    summarize();
  end
endmodule // tb_top
